// ==== logic/ptm_cfg.svh ====
// register offsets, field positions, counter limits and timing counts of the periodic timer
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH
`define PTM_OFS_CTRL0   8'h00
`define PTM_OFS_CTRL1   8'h04
`define PTM_OFS_CNT_LO  8'h08
`define PTM_OFS_CNT_HI  8'h0C
`define PTM_OFS_CMPA_LO 8'h10
`define PTM_OFS_CMPA_HI 8'h14
`define PTM_OFS_PER_LO  8'h18
`define PTM_OFS_PER_HI  8'h1C
`define PTM_OFS_FLAGS   8'h20
`define PTM_RUN_BIT     3
`define PTM_MODE_HI     7
`define PTM_MODE_LO     6
`define PTM_PACT_HI     5
`define PTM_PACT_LO     4
`define PTM_OLVL_BIT    3
`define PTM_INV_BIT     2
`define PTM_CCLR_BIT    0
`define PTM_FLAG_A_BIT  0
`define PTM_FLAG_P_BIT  1
`define PTM_CNT_MAX     10'h3FF
`define PTM_FULL_PERIOD 11'h400
`define PTM_CLK_DIV     4
`endif

// ==== logic/ptm_pkg.sv ====
// types shared by the periodic timer
package ptm_pkg;
  typedef enum logic [1:0] {
    PTM_MODE_CMP = 2'h0,
    PTM_MODE_UND = 2'h1,
    PTM_MODE_PWM = 2'h2,
    PTM_MODE_TMR = 2'h3
  } ptm_mode_t;
  typedef enum logic [1:0] {
    PTM_BUS_IDLE = 2'h1,
    PTM_BUS_ACK  = 2'h2
  } ptm_bus_t;
  typedef struct packed {
    ptm_bus_t    phase;
    logic        waitreq;
    logic [31:0] rdata;
    logic        run;
    ptm_mode_t   mode;
    logic [1:0]  pact;
    logic        olvl;
    logic        inv;
    logic        cclr;
    logic [9:0]  cnt;
    logic [9:0]  cmpa;
    logic [9:0]  per;
    logic        flag_a;
    logic        flag_p;
    logic        cmp_lvl;
    logic [7:0]  div;
    logic        pin_out;
    logic        pin_oe;
  } ptm_state_t;
endpackage

// ==== logic/ptm_timer.sv ====
// 10-bit periodic timer with compare A / period P comparators and an avalon-mm register slave
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "ptm_cfg.svh"

// Function
// (R01) counter readable only, low byte and bits 9..8 in a high register
// (R02) compare A value is 10-bit read/write, split low/high, resets to zero
// (R03) period P value is 10-bit read/write, split low/high, resets to zero
// (R04) high registers read zero in bits 7 to 2
// (R05) two-bit mode field picks compare, pwm, pulse or timer; 00 is compare; code has no pulse mode, 01 is undefined
// (R06) compare, clear-select low: clear on P match or overflow; both flags raised
// (R07) compare, clear-select high: clear on A match; only A flag raised
// (R08) software never sets compare A to zero in compare mode
// (R09) compare A zero: overflow at 3FF and no A flag
// (R10) compare mode pin changes only on an A match
// (R11) pin action picks high, low or toggle; zero means no change
// (R12) run rising edge loads the pin with the initial level bit
// (R13) mode 11 counts and flags like compare mode but leaves the pin undriven
// (R14) software writes 10 to mode and pin action for pwm
// (R15) pwm ignores clear-select; P sets period, A sets duty
// (R16) pwm raises A flag on A match and P flag on P match
// (R17) pwm level bit picks active level; pin action enables or forces
// (R18) invert bit inverts the driven waveform
// (R19) pwm period is P counts, 1024 when P is zero
// (R20) duty at or above period keeps output active all period
// (R21) compare pin codes: 00 none, 01 low, 10 high, 11 toggle
// (R22) run rise zeroes counter; run fall holds the count
// (R23) counter steps once per tick; matches use the incremented count
module ptm_timer #(
  parameter int CLK_DIV = `PTM_CLK_DIV
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // timer output pin
  output logic             pin_out,
  output logic             pin_oe
);
  import ptm_pkg::*;

  ptm_state_t st_r;
  ptm_state_t st_nxt;
  logic       tick;
  logic [9:0] cnt_inc;
  logic       a_hit;
  logic       p_hit;
  logic       set_a;
  logic       set_p;
  logic       clr_a;
  logic       clr_p;
  logic       cnt_clr;
  logic       pwm_act;
  logic       lvl;
  logic [10:0] period;

  // modes 00, 01 and 11 share the compare-match counting rules
  function automatic logic is_cmp_count(input ptm_mode_t m);
    return m != PTM_MODE_PWM;
  endfunction

  // register read decode
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input ptm_state_t s);
    unique case (a)
      `PTM_OFS_CTRL0:   rd_byte = {4'h0, s.run, 3'h0};
      `PTM_OFS_CTRL1:   rd_byte = {s.mode, s.pact, s.olvl, s.inv, 1'b0, s.cclr};
      // (R01) counter view
      `PTM_OFS_CNT_LO:  rd_byte = s.cnt[7:0];
      // (R04) upper bits zero
      `PTM_OFS_CNT_HI:  rd_byte = {6'h00, s.cnt[9:8]};
      `PTM_OFS_CMPA_LO: rd_byte = s.cmpa[7:0];
      `PTM_OFS_CMPA_HI: rd_byte = {6'h00, s.cmpa[9:8]};
      `PTM_OFS_PER_LO:  rd_byte = s.per[7:0];
      `PTM_OFS_PER_HI:  rd_byte = {6'h00, s.per[9:8]};
      `PTM_OFS_FLAGS:   rd_byte = {6'h00, s.flag_p, s.flag_a};
      default:          rd_byte = 8'h00;
    endcase
  endfunction

  // next-state logic: counter, comparators, pin, then bus
  always_comb begin
    st_nxt  = st_r;
    // (R23) tick from divider, compare on incremented count
    tick    = st_r.run && (st_r.div == 8'(CLK_DIV - 1));
    cnt_inc = st_r.cnt + 10'h001;
    a_hit   = tick && (cnt_inc == st_r.cmpa);
    // (R19) P zero matches at wrap, i.e. a 1024 period
    p_hit   = tick && (cnt_inc == st_r.per);
    // (R09) compare A of zero never flags
    set_a   = a_hit && (st_r.cmpa != 10'h000);
    set_p   = 1'b0;
    cnt_clr = 1'b0;
    clr_a   = 1'b0;
    clr_p   = 1'b0;
    if (is_cmp_count(st_r.mode) && st_r.cclr) begin
      // (R07) A match clears, P flag suppressed
      cnt_clr = set_a;
    end else begin
      // (R06) P match or overflow clears; (R15) (R16) same in pwm
      cnt_clr = p_hit;
      set_p   = p_hit;
    end
    // divider runs only with the timer
    if (st_r.run) begin
      st_nxt.div = tick ? 8'h00 : st_r.div + 8'h01;
    end
    if (tick) begin
      st_nxt.cnt = cnt_clr ? 10'h000 : cnt_inc;
    end
    // (R10) (R11) (R21) pin moves only on an A flag in compare mode
    if (st_r.mode == PTM_MODE_CMP && set_a) begin
      unique case (st_r.pact)
        2'h0: st_nxt.cmp_lvl = st_r.cmp_lvl;
        2'h1: st_nxt.cmp_lvl = 1'b0;
        2'h2: st_nxt.cmp_lvl = 1'b1;
        2'h3: st_nxt.cmp_lvl = ~st_r.cmp_lvl;
      endcase
    end
    // bus: one wait cycle, then the answer with waitrequest low
    if (st_r.phase == PTM_BUS_IDLE) begin
      if (read || write) begin
        st_nxt.phase   = PTM_BUS_ACK;
        st_nxt.waitreq = 1'b0;
        st_nxt.rdata   = {24'h000000, rd_byte(address, st_r)};
      end
    end else begin
      st_nxt.phase   = PTM_BUS_IDLE;
      st_nxt.waitreq = 1'b1;
      // writes land on the edge that sees waitrequest low
      if (write && byteenable[0]) begin
        unique case (address)
          `PTM_OFS_CTRL0: st_nxt.run = writedata[`PTM_RUN_BIT];
          `PTM_OFS_CTRL1: begin
            // (R05) mode field select
            st_nxt.mode = ptm_mode_t'(writedata[`PTM_MODE_HI:`PTM_MODE_LO]);
            st_nxt.pact = writedata[`PTM_PACT_HI:`PTM_PACT_LO];
            st_nxt.olvl = writedata[`PTM_OLVL_BIT];
            st_nxt.inv  = writedata[`PTM_INV_BIT];
            st_nxt.cclr = writedata[`PTM_CCLR_BIT];
          end
          // (R02) compare A halves
          `PTM_OFS_CMPA_LO: st_nxt.cmpa[7:0] = writedata[7:0];
          `PTM_OFS_CMPA_HI: st_nxt.cmpa[9:8] = writedata[1:0];
          // (R03) period halves
          `PTM_OFS_PER_LO:  st_nxt.per[7:0] = writedata[7:0];
          `PTM_OFS_PER_HI:  st_nxt.per[9:8] = writedata[1:0];
          `PTM_OFS_FLAGS: begin
            clr_a = writedata[`PTM_FLAG_A_BIT];
            clr_p = writedata[`PTM_FLAG_P_BIT];
          end
          default: st_nxt.run = st_r.run;
        endcase
      end
    end
    // (R22) run rise restarts from zero; a fall just freezes the count
    if (st_nxt.run && !st_r.run) begin
      st_nxt.cnt     = 10'h000;
      st_nxt.div     = 8'h00;
      // (R12) initial pin level
      st_nxt.cmp_lvl = st_nxt.olvl;
    end
    // flags are write-one-to-clear; a same-cycle event wins over the clear
    st_nxt.flag_a = (st_r.flag_a && !clr_a) || set_a;
    st_nxt.flag_p = (st_r.flag_p && !clr_p) || set_p;
    // (R20) duty at or above the period holds the active level
    period  = (st_nxt.per == 10'h000) ? `PTM_FULL_PERIOD : {1'b0, st_nxt.per};
    pwm_act = ({1'b0, st_nxt.cmpa} >= period) || (st_nxt.cnt < st_nxt.cmpa);
    // (R17) pin action forces inactive, active or passes the wave
    unique case (st_nxt.pact)
      2'h0: lvl = ~st_nxt.olvl;
      2'h1: lvl = st_nxt.olvl;
      2'h2: lvl = st_nxt.olvl ? pwm_act : ~pwm_act;
      2'h3: lvl = ~st_nxt.olvl;
    endcase
    if (st_nxt.mode != PTM_MODE_PWM) begin
      lvl = st_nxt.cmp_lvl;
    end
    // (R18) polarity inversion at the pin
    st_nxt.pin_out = st_nxt.inv ^ lvl;
    // (R13) timer mode leaves the pin free; undefined mode does too
    st_nxt.pin_oe  = (st_nxt.mode == PTM_MODE_CMP) || (st_nxt.mode == PTM_MODE_PWM);
  end

  // state register, synchronous active-low reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r         <= '0;
      st_r.phase   <= PTM_BUS_IDLE;
      st_r.waitreq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output straight from the state flops
  assign readdata    = st_r.rdata;
  assign waitrequest = st_r.waitreq;
  assign pin_out     = st_r.pin_out;
  assign pin_oe      = st_r.pin_oe;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  cnt_restart_a: assert property (st_r.run && !$past(st_r.run) |-> st_r.cnt == 10'h000) // (R22)
    else $error("counter not zero after run rise");
  cnt_hold_a: assert property (!st_r.run && !$past(st_r.run) |-> st_r.cnt == $past(st_r.cnt)) // (R22)
    else $error("counter moved while stopped");
  hi_read_a: assert property (st_r.phase == PTM_BUS_IDLE && read && address == `PTM_OFS_CNT_HI
      |=> readdata[31:2] == 30'h0 && readdata[1:0] == $past(st_r.cnt[9:8])) // (R04)
    else $error("counter high read wrong");
  init_lvl_a: assert property (st_r.run && !$past(st_r.run) |-> st_r.cmp_lvl == st_r.olvl) // (R12)
    else $error("initial level not loaded");
  no_pflag_a: assert property (tick && st_r.cclr && is_cmp_count(st_r.mode) && !st_r.flag_p
      |=> !st_r.flag_p) // (R07)
    else $error("period flag raised with clear on A");
  zero_a_flag_a: assert property (tick && st_r.cmpa == 10'h000 && !st_r.flag_a |=> !st_r.flag_a) // (R09)
    else $error("A flag raised with compare A zero");
  p_clear_a: assert property (tick && st_r.run && cnt_inc == st_r.per && !st_r.cclr
      && st_r.phase == PTM_BUS_IDLE |=> st_r.cnt == 10'h000 && st_r.flag_p) // (R06)
    else $error("period match did not clear and flag");
  tmr_pin_a: assert property (st_r.mode == PTM_MODE_TMR |-> !pin_oe) // (R13)
    else $error("pin driven in timer mode");
  full_duty_a: assert property (st_r.mode == PTM_MODE_PWM && st_r.pact == 2'h2
      && st_r.per != 10'h000 && st_r.cmpa >= st_r.per |-> pin_out == (st_r.inv ^ st_r.olvl)) // (R20)
    else $error("full duty not active");
  cmp_pin_a: assert property (st_r.mode == PTM_MODE_CMP && !set_a && st_r.run == $past(st_r.run)
      && st_r.phase == PTM_BUS_IDLE |=> st_r.cmp_lvl == $past(st_r.cmp_lvl)) // (R10)
    else $error("pin moved without A match");
endmodule // ptm_timer

// ==== verification/periodic_timer_10bit_bench.sv ====
// self-checking bench for the periodic timer registers and pin behaviour
`timescale 1ns/10ps
`include "ptm_cfg.svh"
module periodic_timer_10bit_bench;
  logic        ref_clk, rstn, read, write, clr, waitrequest, pin_out, pin_oe, line;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [15:0] hi_cnt, rise_cnt;
  int          num_errors, check_count;
  int          cyc = 0;
  // pwm table: ctrl1, duty, lowest expected high count in 800 cycles
  localparam logic [7:0] PC1 [5] = '{8'hA9, 8'hA8, 8'hAC, 8'h88, 8'h98};
  localparam logic [9:0] PA [5]  = '{10'h2, 10'h8, 10'h2, 10'h2, 10'h2};
  localparam int         PLO [5] = '{196, 796, 596, 0, 796};

  ptm_timer #(.CLK_DIV(1)) dut (.ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_out(pin_out), .pin_oe(pin_oe));
  ptm_pin_load load (.ref_clk(ref_clk), .clr(clr), .pin_out(pin_out), .pin_oe(pin_oe),
    .line(line), .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // watchdog: a hung handshake still reaches the verdict
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // range compare; an unknown never falls inside the range
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("ERROR at %0t got %h exp %h", $time, got, lo);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    xfer(1'b0, a, 8'h00);
    chk(rd, lo, hi);
  endtask

  // split a 10-bit value over its low and high registers
  task automatic setv(input logic [7:0] a, input logic [9:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, {6'h0, v[9:8]});
  endtask

  // stop, configure, clear flags, start and let it run n cycles
  task automatic go(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p, input int n);
    wr(`PTM_OFS_CTRL0, 8'h00);
    setv(`PTM_OFS_CMPA_LO, a);
    setv(`PTM_OFS_PER_LO, p);
    wr(`PTM_OFS_CTRL1, c1);
    wr(`PTM_OFS_FLAGS, 8'h03);
    wr(`PTM_OFS_CTRL0, 8'h08);
    repeat (n) @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    clr = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // value registers come out of reset at zero
    for (int i = 2; i < 8; i++) rc(8'(4 * i), 0, 0);
    wr(`PTM_OFS_CMPA_HI, 8'hFF);
    rc(`PTM_OFS_CMPA_HI, 3, 3);
    wr(`PTM_OFS_PER_LO, 8'hA5);
    rc(`PTM_OFS_PER_LO, 8'hA5, 8'hA5);
    wr(`PTM_OFS_CNT_LO, 8'h5A);
    rc(`PTM_OFS_CNT_LO, 0, 0);
    rc(8'h3C, 0, 0);
    // start loads the initial level before any match
    go(8'h18, 10'h300, 10'h0, 3);
    chk(32'(line), 1, 1);
    // every pin action from a high initial level, one A match each
    for (int i = 0; i < 4; i++) begin
      go({2'h0, 2'(i), 4'h8}, 10'h2, 10'h0, 30);
      wr(`PTM_OFS_CTRL0, 8'h00);
      chk(32'(line), 32'(4'b0101 >> i) & 1, 32'(4'b0101 >> i) & 1);
    end
    // P matches alone leave the pin and the A flag alone
    go(8'h38, 10'h200, 10'h3, 40);
    wr(`PTM_OFS_CTRL0, 8'h00);
    chk(32'(line), 1, 1);
    rc(`PTM_OFS_FLAGS, 2, 2);
    // clear on P with both comparators matching
    go(8'h00, 10'h3, 10'h5, 40);
    wr(`PTM_OFS_CTRL0, 8'h00);
    rc(`PTM_OFS_FLAGS, 3, 3);
    rc(`PTM_OFS_CNT_LO, 0, 5);
    // clear on A; P below A raises no P flag
    go(8'h01, 10'h4, 10'h2, 40);
    wr(`PTM_OFS_CTRL0, 8'h00);
    rc(`PTM_OFS_FLAGS, 1, 1);
    rc(`PTM_OFS_CNT_LO, 0, 4);
    // timer mode with A zero: wraps past 3FF without an A flag, pin released
    go(8'hC0, 10'h0, 10'h0, 1100);
    chk(32'(pin_oe), 0, 0);
    wr(`PTM_OFS_CTRL0, 8'h00);
    rc(`PTM_OFS_FLAGS, 2, 2);
    rc(`PTM_OFS_CNT_HI, 0, 0);
    repeat (20) @(posedge ref_clk);
    rc(`PTM_OFS_CNT_LO, 70, 90);
    go(8'hC0, 10'h0, 10'h0, 5);
    wr(`PTM_OFS_CTRL0, 8'h00);
    rc(`PTM_OFS_CNT_LO, 0, 10);
    // pwm with period 8: duty, full duty, invert, forced levels
    for (int i = 0; i < 5; i++) begin
      go(PC1[i], PA[i], 10'h8, 20);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (800) @(posedge ref_clk);
      chk(32'(hi_cnt), PLO[i], PLO[i] + 8);
      if (i == 0) chk(32'(rise_cnt), 99, 101);
      wr(`PTM_OFS_CTRL0, 8'h00);
      if (i == 0) rc(`PTM_OFS_FLAGS, 3, 3);
    end
    test_done();
  end
endmodule // periodic_timer_10bit_bench

// ==== verification/ptm_pin_load.sv ====
// external load on the timer pin: pull-down line plus level and edge counters
`timescale 1ns/10ps
module ptm_pin_load (
  // clock and measurement control
  input  wire logic        ref_clk,
  input  wire logic        clr,
  // timer pin
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  // observed line and counts
  output logic             line,
  output logic [15:0]      hi_cnt,
  output logic [15:0]      rise_cnt
);
  logic prev_r;
  // pull-down takes the line low whenever the timer releases it
  assign line = pin_oe ? pin_out : 1'b0;
  // high cycles and rising edges since the last clear
  always_ff @(posedge ref_clk) begin
    prev_r   <= line;
    hi_cnt   <= clr ? 16'h0 : hi_cnt + {15'h0, line};
    rise_cnt <= clr ? 16'h0 : rise_cnt + {15'h0, line & ~prev_r};
  end
endmodule // ptm_pin_load
